/* File: hw/pfp_pkg.sv */
// Shared constants and types for the dual-slope phase and frequency correct PWM timer.
package pfp_pkg;
  // Register byte offsets on the AXI4-Lite slave.
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMP_A = 8'h04;
  localparam logic [7:0] ADDR_CMP_B = 8'h08;
  localparam logic [7:0] ADDR_CAPTOP = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register field positions.
  localparam int CTRL_W = 15;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACT_A_LSB = 4;
  localparam int CTRL_ACT_B_LSB = 6;
  localparam int CTRL_CSEL_LSB = 8;
  localparam int CTRL_DIR_A_BIT = 11;
  localparam int CTRL_DIR_B_BIT = 12;
  localparam int CTRL_PORT_A_BIT = 13;
  localparam int CTRL_PORT_B_BIT = 14;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;

  // Flag register bit positions.
  localparam int FLAG_W = 4;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_MATCH_A_BIT = 1;
  localparam int FLAG_MATCH_B_BIT = 2;
  localparam int FLAG_CAPTURE_BIT = 3;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;

  // Counter values and reset values.
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] TOP_MIN = 16'h0003;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CAPTOP_RESET = 16'h0000;

  // Waveform mode codes that this block acts on.
  localparam logic [3:0] MODE_PFC_CAPTURE = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP_A = 4'h9;
  localparam logic [3:0] MODE_PC_CMP_A = 4'hB;

  // Prescaler masks: a tick fires when the masked low count bits are all ones.
  localparam logic [9:0] PRE_MASK_DIV1 = 10'h000;
  localparam logic [9:0] PRE_MASK_DIV8 = 10'h007;
  localparam logic [9:0] PRE_MASK_DIV64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_DIV1024 = 10'h3FF;

  typedef enum logic [2:0] {
    CSEL_STOP = 3'b000,
    CSEL_DIV1 = 3'b001,
    CSEL_DIV8 = 3'b010,
    CSEL_DIV64 = 3'b011,
    CSEL_DIV256 = 3'b100,
    CSEL_DIV1024 = 3'b101
  } pfp_clk_sel_e;

  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_NONINV = 2'b10,
    ACT_INV = 2'b11
  } pfp_action_e;
endpackage

/* File: hw/pfp_tick_if.sv */
// Carrier between the timer core and its tick prescaler.
`timescale 1ns/1ps
interface pfp_tick_if;
  import pfp_pkg::*;
  logic [2:0] clk_sel;
  logic tick;
  modport src (input clk_sel, output tick);
  modport ctl (output clk_sel, input tick);
endinterface

/* File: hw/pfp_prescaler.sv */
// Prescaler that turns the selected divider into a one-cycle timer tick enable.
`timescale 1ns/1ps
module pfp_prescaler
  import pfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  pfp_tick_if.src tick_bus
);
  logic [9:0] pre_cnt_reg;
  logic [9:0] pre_mask;
  logic run;

  // Divider decode; unused select codes stop the timer rather than guess a rate.
  always_comb begin
    run = 1'b1;
    pre_mask = PRE_MASK_DIV1;
    unique case (tick_bus.clk_sel)
      CSEL_STOP: run = 1'b0;
      CSEL_DIV1: pre_mask = PRE_MASK_DIV1;
      CSEL_DIV8: pre_mask = PRE_MASK_DIV8;
      CSEL_DIV64: pre_mask = PRE_MASK_DIV64;
      CSEL_DIV256: pre_mask = PRE_MASK_DIV256;
      CSEL_DIV1024: pre_mask = PRE_MASK_DIV1024;
      default: run = 1'b0;
    endcase
  end

  // Free-running divider count, held at zero while stopped.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_cnt_reg <= 10'h000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 10'h001;
    end
  end

  // The tick is an enable in the same clock domain, never a derived clock.
  assign tick_bus.tick = run && ((pre_cnt_reg & pre_mask) == pre_mask);
endmodule

/* File: hw/pfp_pwm_top.sv */
// Phase and frequency correct dual-slope PWM timer with an AXI4-Lite register slave.
//
// Overview of operation
// [RL1] Waveform modes 8 and 9 run dual-slope PWM.
// [RL2] Count up from zero to TOP, then down.
// [RL3] Non-inverting: clear on up match, set down.
// [RL4] TOP is capture value (8) or compare A (9).
// [RL5] TOP from 0x0003 up to full 16 bits.
// [RL6] Counter holds TOP for exactly one tick.
// [RL7] Match flag set on both slopes.
// [RL8] Compare buffers load at BOTTOM with overflow flag.
// [RL9] Compare A or capture flag set at TOP.
// [RL10] TOP below compare value gives no match.
// [RL11] Slopes equal length every period.
// [RL12] Buffered compare A suits changing TOP.
// [RL13] Action two non-inverted, three inverted PWM.
// [RL14] Pin driven only when direction selects output.
// [RL15] Compare at BOTTOM low, at TOP high.
// [RL16] Mode 9 action 1 toggles A, half duty.
// [RL17] Tick divider 1, 8, 64, 256 or 1024.
// [RL18] Fully synchronous; tick is only an enable.
// [RL19] BOTTOM events use the TOP event timing.
// [RL20] Action 0 disconnects; 1 toggles A in 9/11; here A never toggles in 11, where the counter does not run.
// [RL21] Nonzero action overrides the pin's port function; here action 1 overrides it only on A in modes 9 and 11.
// [RL22] Matches, reversal and flags only on ticks.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module pfp_pwm_top
  import pfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] compare_output_pin,
  output logic [1:0] compare_output_oe_n
);
  // Bus handshake state.
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [AXI_AW-1:0] awaddr_held_reg;
  logic [31:0] wdata_held_reg;
  logic [3:0] wstrb_held_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic wr_hit;
  logic aw_held_next;
  logic w_held_next;
  logic rvalid_next;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic rd_hit;

  // Software-visible state.
  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0] cmp_buf_reg [2];
  logic [15:0] cmp_act_reg [2];
  logic [15:0] captop_reg;
  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_set;
  logic [FLAG_W-1:0] flags_clr;

  // Counter core state.
  logic [15:0] counter_value_reg;
  logic dir_up_reg;
  logic [1:0] compare_output_reg;
  logic [1:0] pin_out_reg;
  logic [1:0] oe_n_reg;

  // Decoded control fields and core events.
  logic [3:0] waveform_mode_sel;
  logic [1:0] match_evt;
  logic pfc_mode;
  logic toggle_mode;
  logic [15:0] top_value;
  logic at_top;
  logic at_bottom;
  logic slope_up;
  logic timer_tick;
  logic load_evt;

  pfp_tick_if tick_bus ();

  // The divider select steers the prescaler; its tick enables the counter.
  assign tick_bus.clk_sel = ctrl_reg[CTRL_CSEL_LSB +: 3];
  // [RL17] Selectable tick divider.
  pfp_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_bus(tick_bus)
  );
  assign timer_tick = tick_bus.tick;

  // Bus outputs come straight from their flip-flops.
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign compare_output_pin = pin_out_reg;
  assign compare_output_oe_n = oe_n_reg;

  // Write channel bookkeeping; address and data may arrive in either order.
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
  assign aw_held_next = (aw_held_reg || aw_take) && !wr_do;
  assign w_held_next = (w_held_reg || w_take) && !wr_do;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

  // Byte enables widen into a bit mask, one lane per byte.
  for (genvar gb = 0; gb < 4; gb++) begin : g_lane
    assign wmask[gb*8 +: 8] = {8{wstrb_held_reg[gb]}};
  end

  // Write address decode; the flags word is writable too, while a counter write is acknowledged but ignored.
  always_comb begin
    unique case (awaddr_held_reg)
      ADDR_CTRL, ADDR_CMP_A, ADDR_CMP_B, ADDR_CAPTOP, ADDR_FLAGS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write side handshake registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= !aw_held_next;
      wready_reg <= !w_held_next;
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_hit || awaddr_held_reg == ADDR_COUNT) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Captured write payload; no reset needed as it is only read under the held flags.
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      awaddr_held_reg <= s_axi_awaddr;
    end
    if (w_take) begin
      wdata_held_reg <= s_axi_wdata;
      wstrb_held_reg <= s_axi_wstrb;
    end
  end

  // Read mux; unused bits read as zero.
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd_word[CTRL_W-1:0] = ctrl_reg;
      ADDR_CMP_A: rd_word[15:0] = cmp_buf_reg[0];
      ADDR_CMP_B: rd_word[15:0] = cmp_buf_reg[1];
      ADDR_CAPTOP: rd_word[15:0] = captop_reg;
      ADDR_COUNT: rd_word[15:0] = counter_value_reg;
      ADDR_FLAGS: rd_word[FLAG_W-1:0] = flags_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read side: one read in flight, data registered one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rvalid_reg <= rvalid_next;
      arready_reg <= !rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control, compare buffers and capture TOP, written with byte enables.
  // [RL12] Compare A goes through its buffer, capture TOP does not.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      cmp_buf_reg[0] <= CMP_RESET;
      cmp_buf_reg[1] <= CMP_RESET;
      captop_reg <= CAPTOP_RESET;
    end else if (wr_do) begin
      unique case (awaddr_held_reg)
        ADDR_CTRL: ctrl_reg <= (ctrl_reg & ~wmask[CTRL_W-1:0])
                               | (wdata_held_reg[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
        ADDR_CMP_A: cmp_buf_reg[0] <= (cmp_buf_reg[0] & ~wmask[15:0])
                                      | (wdata_held_reg[15:0] & wmask[15:0]);
        ADDR_CMP_B: cmp_buf_reg[1] <= (cmp_buf_reg[1] & ~wmask[15:0])
                                      | (wdata_held_reg[15:0] & wmask[15:0]);
        ADDR_CAPTOP: captop_reg <= (captop_reg & ~wmask[15:0])
                                   | (wdata_held_reg[15:0] & wmask[15:0]);
        default: ;
      endcase
    end
  end

  // Mode decode and TOP selection.
  assign waveform_mode_sel = ctrl_reg[CTRL_MODE_LSB +: 4];
  // [RL1] Dual-slope in modes 8 and 9.
  assign pfc_mode = (waveform_mode_sel == MODE_PFC_CAPTURE)
                    || (waveform_mode_sel == MODE_PFC_CMP_A);
  assign toggle_mode = (waveform_mode_sel == MODE_PFC_CMP_A)
                       || (waveform_mode_sel == MODE_PC_CMP_A);
  // [RL4] TOP source by mode.
  assign top_value = (waveform_mode_sel == MODE_PFC_CMP_A) ? cmp_act_reg[0] : captop_reg;
  assign at_top = (counter_value_reg == top_value);
  assign at_bottom = (counter_value_reg == COUNT_BOTTOM);

  // The slope a match belongs to: BOTTOM counts as rising and TOP as falling,
  // so a compare value at either extreme yields a constant level.
  // [RL15] Extreme compare values.
  assign slope_up = at_bottom ? 1'b1 : (at_top ? 1'b0 : dir_up_reg);

  // [RL8] Buffer load and overflow at BOTTOM.
  // [RL19] Same tick as the TOP events elsewhere.
  assign load_evt = timer_tick && pfc_mode && at_bottom;

  // Dual-slope counter. A TOP below the minimum is not supported; a TOP lowered
  // under the count lets the counter run on and wrap before it meets TOP again.
  // [RL18] Tick is only an enable on aclk.
  // [RL5] Full 16-bit TOP range.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value_reg <= COUNT_BOTTOM;
      dir_up_reg <= 1'b1;
    end else if (timer_tick && pfc_mode) begin
      if (!dir_up_reg && at_bottom) begin
        // [RL2] Reverse at BOTTOM.
        dir_up_reg <= 1'b1;
        counter_value_reg <= counter_value_reg + COUNT_ONE;
      end else if (dir_up_reg && at_top && !at_bottom) begin
        // [RL6] TOP held one tick, then down.
        dir_up_reg <= 1'b0;
        counter_value_reg <= counter_value_reg - COUNT_ONE;
      end else if (dir_up_reg) begin
        counter_value_reg <= counter_value_reg + COUNT_ONE;
      end else begin
        counter_value_reg <= counter_value_reg - COUNT_ONE;
      end
    end
  end

  // Per-channel compare units.
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [1:0] output_action_sel;
    logic connected;
    logic dir_bit;
    logic port_bit;
    logic is_a;

    assign is_a = (ch == 0);
    assign output_action_sel = ctrl_reg[CTRL_ACT_A_LSB + 2*ch +: 2];
    assign dir_bit = ctrl_reg[CTRL_DIR_A_BIT + ch];
    assign port_bit = ctrl_reg[CTRL_PORT_A_BIT + ch];
    // [RL22] Match only on a tick.
    // [RL7] Both slopes; [RL10] never past TOP.
    assign match_evt[ch] = timer_tick && pfc_mode && (counter_value_reg == cmp_act_reg[ch]);

    // Active compare loads only at BOTTOM, so both slopes see one compare value and,
    // in mode 9, one TOP; outside these modes the buffer passes straight through.
    // [RL11] Symmetric slopes.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cmp_act_reg[ch] <= CMP_RESET;
      end else if (!pfc_mode || load_evt) begin
        cmp_act_reg[ch] <= cmp_buf_reg[ch];
      end
    end

    // Compare output level driven by matches.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        compare_output_reg[ch] <= 1'b0;
      end else if (match_evt[ch]) begin
        unique case (output_action_sel)
          // [RL3] [RL13] Non-inverted PWM.
          ACT_NONINV: compare_output_reg[ch] <= !slope_up;
          // [RL13] Inverted PWM.
          ACT_INV: compare_output_reg[ch] <= slope_up;
          // [RL16] Toggle channel A.
          ACT_TOGGLE: begin
            if (is_a && toggle_mode) begin
              compare_output_reg[ch] <= !compare_output_reg[ch];
            end
          end
          ACT_OFF: ;
        endcase
      end
    end

    // [RL20] Which action codes connect the pin.
    assign connected = (output_action_sel == ACT_NONINV)
                       || (output_action_sel == ACT_INV)
                       || (output_action_sel == ACT_TOGGLE && is_a && toggle_mode);

    // Pin mux, one cycle behind the compare level so the port is a flop.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_out_reg[ch] <= 1'b0;
        oe_n_reg[ch] <= 1'b1;
      end else begin
        // [RL21] Compare level overrides port data.
        pin_out_reg[ch] <= connected ? compare_output_reg[ch] : port_bit;
        // [RL14] Driver follows direction bit.
        oe_n_reg[ch] <= !dir_bit;
      end
    end
  end

  // Hardware flag events.
  // [RL9] Capture flag at TOP in mode 8.
  always_comb begin
    flags_set = '0;
    flags_set[FLAG_OVF_BIT] = load_evt;
    flags_set[FLAG_MATCH_A_BIT] = match_evt[0];
    flags_set[FLAG_MATCH_B_BIT] = match_evt[1];
    flags_set[FLAG_CAPTURE_BIT] = timer_tick && at_top
                                  && (waveform_mode_sel == MODE_PFC_CAPTURE);
  end
  assign flags_clr = (wr_do && awaddr_held_reg == ADDR_FLAGS)
                     ? (wdata_held_reg[FLAG_W-1:0] & wmask[FLAG_W-1:0]) : '0;

  // Write one to clear; a flag set in the clearing cycle stays set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= (flags_reg & ~flags_clr) | flags_set;
    end
  end

  // Protection bits carry no meaning for this slave.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule

/* File: dv/pfp_pwm_monitor.sv */
// Checker on the timer top's ports: register bus handshakes and pin drivers.
`timescale 1ns/1ps
module pfp_pwm_monitor
  import pfp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] compare_output_pin,
  input wire logic [1:0] compare_output_oe_n
);
  // All checks sample on the bus clock and rest while reset is low.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved before bready");
  chk_bvalid_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_write_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved before rready");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  chk_pins_reset: assert property (
    $rose(aresetn) |-> compare_output_oe_n == 2'h3 && compare_output_pin == 2'h0)
    else $error("pin drivers on after reset");
  chk_ready_rise: assert property (
    $rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("bus not ready after reset");
  // Main scenarios seen at least once.
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cov_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
  cov_pin_rise: cover property ($rose(compare_output_pin[0]));
endmodule

/* File: dv/pfp_load_model.sv */
// Load on the two compare pins, such as a motor driver input with a pull-down.
`timescale 1ns/1ps
module pfp_load_model (
  input wire logic [1:0] pin_level,
  input wire logic [1:0] pin_oe_n,
  output logic [1:0] line_level
);
  // A released pin floats, so the pull-down takes the line low.
  assign line_level = pin_level & ~pin_oe_n;
endmodule

/* File: dv/test_dual_slope_freq_correct_pwm.sv */
// Self-checking bench for the dual-slope PWM timer: bus, waveforms and flags.
`timescale 1ns/1ps
module test_dual_slope_freq_correct_pwm;
  import pfp_pkg::*;
  logic aclk, awready, wready, bvalid, arready, rvalid;
  logic aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, slow = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, pin, oe_n, line;
  int miscompares = 0;
  int num_checks = 0;
  // Free-running 50 MHz clock.
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  pfp_pwm_top DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compare_output_pin(pin), .compare_output_oe_n(oe_n));
  // The load sees each pin only through its driver.
  pfp_load_model u_load (.pin_level(pin), .pin_oe_n(oe_n), .line_level(line));
  // Compare one value and count the outcome.
  task automatic check(input logic [31:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  // Verdict and end of run.
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Synchronous reset held for the given number of cycles.
  task automatic do_reset(input int cycles);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (cycles) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask
  // One write; a slow master raises bready only once the response shows.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= !slow;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (!bready) bready <= bvalid;
    end while (!(bvalid && bready) && n < 100);
    check(bvalid && bready, 1'h1, "write answer");
    check(bresp, er, "write response");
    bready <= 1'h0;
    if (!(bvalid && bready)) final_report();
  endtask
  // One read, judged against the expected word and response.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= !slow;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
      if (!rready) rready <= rvalid;
    end while (!(rvalid && rready) && n < 100);
    check(rvalid && rready, 1'h1, "read answer");
    check(rdata, ed, "read data");
    check(rresp, er, "read response");
    rready <= 1'h0;
    if (!(rvalid && rready)) final_report();
  endtask
  // Program a waveform, measure four whole periods on the lines, stop, then read flags.
  // Counting highs and rises over whole periods makes the result independent of phase.
  task automatic run_pwm(input logic [3:0] mode, input logic [15:0] top, ca, cb,
      input logic [1:0] aa, ab, input logic [2:0] csel, input logic [1:0] dir, port,
      input int hi_a, hi_b, rise_a, rise_b, input logic [3:0] flags);
    int div, ha = 0, hb = 0, ra = 0, rb = 0;
    logic [1:0] prev;
    logic [31:0] ctrl;
    div = (csel == CSEL_DIV1) ? 1 : (csel == CSEL_DIV8) ? 8 : (csel == CSEL_DIV64) ? 64 :
        (csel == CSEL_DIV256) ? 256 : 1024;
    ctrl = {17'h0, port, dir, csel, ab, aa, mode};
    do_reset(2);
    axi_wr(ADDR_CAPTOP, {16'h0, top}, RESP_OKAY);
    axi_wr(ADDR_CMP_A, {16'h0, ca}, RESP_OKAY);
    axi_wr(ADDR_CMP_B, {16'h0, cb}, RESP_OKAY);
    axi_wr(ADDR_CTRL, ctrl, RESP_OKAY);
    repeat (4 * top * div + 4) @(posedge aclk);
    prev = line;
    repeat (8 * top * div) begin
      @(posedge aclk);
      ha += line[0];
      hb += line[1];
      ra += line[0] & !prev[0];
      rb += line[1] & !prev[1];
      prev = line;
    end
    check(ha, 4 * div * hi_a, "high time a");
    check(hb, 4 * div * hi_b, "high time b");
    check(ra, rise_a, "rises a");
    check(rb, rise_b, "rises b");
    check(2'(~dir), oe_n, "pin enables");
    axi_wr(ADDR_CTRL, ctrl & 32'hFFFF_F8FF, RESP_OKAY);
    axi_rd(ADDR_FLAGS, {28'h0, flags}, RESP_OKAY);
    axi_wr(ADDR_FLAGS, 32'hF, RESP_OKAY);
    axi_rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
  endtask
  // reset values, unmapped place, read-only counter, mode outside 8 and 9.
  task automatic scen_bus();
    slow = 1'h1;
    axi_rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    axi_rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    axi_wr(8'h18, 32'hFFFF, RESP_SLVERR);
    axi_rd(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(ADDR_CMP_B, 32'hFFFF_1234, RESP_OKAY);
    axi_rd(ADDR_CMP_B, 32'h0000_1234, RESP_OKAY);
    axi_wr(ADDR_COUNT, 32'h1234, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h0000_0100, RESP_OKAY);
    repeat (20) @(posedge aclk);
    axi_rd(ADDR_COUNT, 32'h0, RESP_OKAY);
    slow = 1'h0;
  endtask
  // Both modes, every action code and every divider.
  task automatic scen_waves();
    run_pwm(MODE_PFC_CAPTURE, 16'h0004, 16'h0002, 16'h0001, ACT_NONINV, ACT_INV,
        CSEL_DIV1, 2'h3, 2'h0, 4, 6, 4, 4, 4'hF);
    // minimum TOP, compare at BOTTOM and at TOP.
    run_pwm(MODE_PFC_CAPTURE, 16'h0003, 16'h0000, 16'h0003, ACT_NONINV, ACT_NONINV,
        CSEL_DIV8, 2'h3, 2'h0, 0, 6, 0, 0, 4'hF);
    // toggle on A, B left to its port bit with compare above TOP.
    run_pwm(MODE_PFC_CMP_A, 16'h0004, 16'h0004, 16'h0009, ACT_TOGGLE, ACT_TOGGLE,
        CSEL_DIV64, 2'h3, 2'h2, 4, 8, 2, 0, 4'h3);
    // driver of A off, inverted B at BOTTOM.
    run_pwm(MODE_PFC_CAPTURE, 16'h0003, 16'h0003, 16'h0000, ACT_INV, ACT_INV,
        CSEL_DIV256, 2'h2, 2'h0, 0, 6, 0, 0, 4'hF);
    // action off on A, slowest divider.
    run_pwm(MODE_PFC_CMP_A, 16'h0003, 16'h0003, 16'h0001, ACT_OFF, ACT_NONINV,
        CSEL_DIV1024, 2'h3, 2'h1, 6, 2, 0, 4, 4'h7);
  endtask
  // Reset, the scenarios and the verdict.
  initial begin
    do_reset(16);
    scen_bus();
    scen_waves();
    final_report();
  end
endmodule

// Checker attached to every instance of the timer top.
bind pfp_pwm_top pfp_pwm_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .compare_output_pin(compare_output_pin), .compare_output_oe_n(compare_output_oe_n));
